// File: pvs_event_latch.sv
// Clear-on-read latch of unmasked source changes
`include "pvs_map.svh"
module pvs_event_latch (
    input  wire logic            core_clk,
    input  wire logic            nrst,
    input  wire pvs_pkg::pvs_byte_t liveStatus,
    input  wire pvs_pkg::pvs_byte_t eventMask,
    input  wire logic            clearAll,
    output pvs_pkg::pvs_byte_t   latchValue
);
    import pvs_pkg::*;

    pvs_byte_t prevStatus;
    pvs_byte_t next_latch;
    logic      accEvent;
    logic      primed;

    // Edge detection waits one cycle after reset so sources already high are no event
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prevStatus <= 8'h00;
            primed     <= 1'b0;
        end else begin
            prevStatus <= liveStatus;
            primed     <= 1'b1;
        end
    end

    assign accEvent = primed && eventMask[2] && (liveStatus[3:2] != prevStatus[3:2])
                      && (liveStatus[3:2] != 2'h0);

    always_comb begin
        next_latch = clearAll ? 8'h00 : latchValue;
        for (int i = 0; i < 8; i++) begin
            // The watchdog bit latches only on expiry, not on its release
            if (i != 1 && i != 2 && i != 3 && eventMask[i] && primed
                && (liveStatus[i] != prevStatus[i])
                && (i != `PVS_BIT_WDOG || liveStatus[i])) begin
                next_latch[i] = 1'b1;
            end
        end
        if (accEvent) begin
            next_latch[3:2] = liveStatus[3:2];
        end
        next_latch[1] = 1'b0;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            latchValue <= 8'h00;
        end else begin
            latchValue <= next_latch;
        end
    end

    AST_EVENT_WINS: assert property (@(posedge core_clk) disable iff (!nrst)
        (primed && eventMask[`PVS_BIT_VBUS] && $changed(liveStatus[`PVS_BIT_VBUS]))
        |=> latchValue[`PVS_BIT_VBUS])
        else $error("vbus event lost");
    AST_CLEAR_EMPTIES: assert property (@(posedge core_clk) disable iff (!nrst)
        (clearAll && eventMask == 8'h00) |=> latchValue == 8'h00)
        else $error("latch not cleared");
    AST_ACC_NONZERO: assert property (@(posedge core_clk) disable iff (!nrst)
        accEvent |=> latchValue[3:2] != 2'h0)
        else $error("accessory latch zero after event");
endmodule : pvs_event_latch

// File: pvs_link_model.sv
// Link-side model: register write and read cycles toward the vendor bank
`include "pvs_map.svh"
module pvs_link_model (
    input  wire logic               core_clk,
    input  wire pvs_pkg::pvs_byte_t regRdata,
    output logic                    regWrite,
    output logic                    regRead,
    output pvs_pkg::pvs_byte_t      regAddr,
    output pvs_pkg::pvs_byte_t      regWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import pvs_pkg::*;

    initial begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // One write cycle; the top charger bit is never sent as one
    task automatic wr(input pvs_byte_t a, input pvs_byte_t d);
        @(negedge core_clk);
        regAddr  = a;
        regWdata = (a inside {`PVS_ADDR_CHG, `PVS_ADDR_CHG_SET, `PVS_ADDR_CHG_CLR}) ?
                   (d & 8'h7f) : d;
        regWrite = 1'b1;
        @(negedge core_clk);
        regWrite = 1'b0;
        regWdata = ~regWdata;
    endtask

    // One read cycle; data is taken at the falling edge after the read edge
    task automatic rd(input pvs_byte_t a, output pvs_byte_t d);
        @(negedge core_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge core_clk);
        regRead = 1'b0;
        d       = regRdata;
    endtask
endmodule // pvs_link_model

// File: pvs_map.svh
// Register offsets, field positions, reset values and write masks of the vendor register bank
`ifndef PVS_MAP_SVH
`define PVS_MAP_SVH

`define PVS_ADDR_LIVE        8'h83
`define PVS_ADDR_LATCH       8'h84
`define PVS_ADDR_CHG         8'h85
`define PVS_ADDR_CHG_SET     8'h86
`define PVS_ADDR_CHG_CLR     8'h87
`define PVS_ADDR_ACC         8'h88
`define PVS_ADDR_ACC_SET     8'h89
`define PVS_ADDR_ACC_CLR     8'h8a

`define PVS_BIT_VBUS         7
`define PVS_BIT_BATT         6
`define PVS_BIT_WDOG         5
`define PVS_BIT_IDFLOAT      4
`define PVS_BIT_BVALID       0

`define PVS_CHG_SRC_EN       6
`define PVS_CHG_WKPU         5
`define PVS_CHG_FSM_EN       4
`define PVS_CHG_DCD_EN       3

`define PVS_ACC_ACA_EN       6
`define PVS_ACC_RABUS        5
`define PVS_ACC_R1K          4
`define PVS_ACC_OSOD         3
`define PVS_ACC_CMOS         2

`define PVS_CHG_RESET        8'h03
`define PVS_ACC_RESET        8'h70
`define PVS_CHG_WMASK        8'h7f
`define PVS_ACC_WMASK        8'h7c

`endif

// File: pvs_pkg.sv
// Types shared by the vendor register bank
package pvs_pkg;
    typedef logic [7:0] pvs_byte_t;
    typedef enum logic [1:0] {
        PVS_PSW_OPEN_SOURCE,
        PVS_PSW_OPEN_DRAIN,
        PVS_PSW_PUSH_PULL
    } pvs_psw_mode_t;
endpackage : pvs_pkg

// File: pvs_reg_port.sv
// Register access decode: turns a read or write strobe into per-register selects
`include "pvs_map.svh"
module pvs_reg_port (
    input  wire logic            regWrite,
    input  wire logic            regRead,
    input  wire pvs_pkg::pvs_byte_t regAddr,
    output logic                 selLatchRead,
    output logic [1:0]           chgOp,
    output logic [1:0]           accOp,
    output logic                 addrMapped
);
    import pvs_pkg::*;

    // Op: 0 none, 1 write, 2 set, 3 clear
    always_comb begin
        chgOp        = 2'h0;
        accOp        = 2'h0;
        selLatchRead = regRead && (regAddr == `PVS_ADDR_LATCH);
        addrMapped   = (regAddr >= `PVS_ADDR_LIVE) && (regAddr <= `PVS_ADDR_ACC_CLR);
        if (regWrite) begin
            unique case (regAddr)
                `PVS_ADDR_CHG:     chgOp = 2'h1;
                `PVS_ADDR_CHG_SET: chgOp = 2'h2;
                `PVS_ADDR_CHG_CLR: chgOp = 2'h3;
                `PVS_ADDR_ACC:     accOp = 2'h1;
                `PVS_ADDR_ACC_SET: accOp = 2'h2;
                `PVS_ADDR_ACC_CLR: accOp = 2'h3;
                default: begin
                    chgOp = 2'h0;
                    accOp = 2'h0;
                end
            endcase
        end
    end
endmodule : pvs_reg_port

// File: pvs_vendor_regs.sv
// Vendor status, event latch, charger detect and accessory configuration register bank
// Operation
// - Live status read returns present source levels, no stored history.
// - Accessory status bits 3:2 give 00 none, 01 A, 10 B, 11 C.
// - A latch bit sets on an unmasked change of its source.
// - Reading the latch register, or entering low power or serial mode, clears all latch bits except any set by an event in that cycle.
// - Watchdog expiry sets latch bit 5; status bit 5 shows expiry live.
// - Latch bits 4 and 0 capture ID float and B-session changes.
// - Accessory latch field loads nonzero code on event; 00 means none.
// - Current source enable mirrors FSM unless software control, then writable.
// - Voltage source plus current source disables current source and DM pulldown.
// - Weak pullup sampling acts only while main ID pullup is off.
// - Charger FSM runs only with enable set and software control off.
// - Dead-battery detection sets FSM enable; writing 0 stops it.
// - FSM enable cleared while software control is on, and at reset.
// - Connect counter timeout clears FSM enable; software re-enables it.
// - Contact detect step included when FSM enabled and bit 3 set.
// - Regulator select bits 2:0 reset to 011 and drive regulator code.
// - Accessory detect enable bit 6 resets to 1 and gates ACA detection.
// - Bit 5 enables A-device VBUS resistor; bit 4 shifts thresholds.
// - Power switch open source or open drain per bit 3; bit 2 forces push-pull.
// - Bits 1:0 show debounced DP and DM receiver levels, valid when enabled.
// - Set alias write sets bits written as one; read returns register.
// - Clear alias write clears bits written as one.
`include "pvs_map.svh"
module pvs_vendor_regs (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               regWrite,
    input  wire logic               regRead,
    input  wire pvs_pkg::pvs_byte_t regAddr,
    input  wire pvs_pkg::pvs_byte_t regWdata,
    output pvs_pkg::pvs_byte_t      regRdata,
    input  wire logic               vbusMonitorLive,
    input  wire logic               batteryLevelMonitorLive,
    input  wire logic               connectWatchdogExpired,
    input  wire logic               idLineFloatLive,
    input  wire logic [1:0]         accessoryResistorCode,
    input  wire logic               bSessionValidLive,
    input  wire pvs_pkg::pvs_byte_t eventMask,
    input  wire logic               lowPowerEntry,
    input  wire logic               serialModeEntry,
    input  wire logic               softwareChargerControl,
    input  wire logic               dpVoltageSourceEnable,
    input  wire logic               dpWeakPullupEnable,
    input  wire logic               idMainPullup,
    input  wire logic               fsmSourceControl,
    input  wire logic               deadBatteryDetect,
    input  wire logic               sessionConnectTimeout,
    input  wire logic               dpSingleEndedLevel,
    input  wire logic               dmSingleEndedLevel,
    output logic                    chargerFsmRun,
    output logic                    contactDetectStep,
    output logic                    dataContactSourceOn,
    output logic                    dmPulldownOn,
    output logic                    idWeakPullupSample,
    output logic [2:0]              regulatorVoltageSelect,
    output logic                    accessoryDetectEnable,
    output logic                    aDeviceVbusResistorEnable,
    output logic                    externalSeriesResistorPresent,
    output pvs_pkg::pvs_psw_mode_t  powerSwitchMode
);
    import pvs_pkg::*;

    pvs_byte_t  liveStatus;
    pvs_byte_t  latchValue;
    pvs_byte_t  chgReg;
    pvs_byte_t  accReg;
    pvs_byte_t  chgView;
    pvs_byte_t  accView;
    pvs_byte_t  next_chg;
    pvs_byte_t  next_acc;
    pvs_byte_t  next_rdata;
    logic       selLatchRead;
    logic [1:0] chgOp;
    logic [1:0] accOp;
    logic       addrMapped;
    logic       prevLowPower;
    logic       prevSerial;
    logic       clearAll;
    logic       srcEnEff;
    logic       prevDeadBatt;

    // Live levels, bit 1 reserved
    assign liveStatus = {vbusMonitorLive, batteryLevelMonitorLive, connectWatchdogExpired,
                         idLineFloatLive, accessoryResistorCode, 1'b0,
                         bSessionValidLive};

    pvs_reg_port uPort (
        .regWrite     (regWrite),
        .regRead      (regRead),
        .regAddr      (regAddr),
        .selLatchRead (selLatchRead),
        .chgOp        (chgOp),
        .accOp        (accOp),
        .addrMapped   (addrMapped)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prevLowPower <= 1'b0;
            prevSerial   <= 1'b0;
            prevDeadBatt <= 1'b0;
        end else begin
            prevLowPower <= lowPowerEntry;
            prevSerial   <= serialModeEntry;
            prevDeadBatt <= deadBatteryDetect;
        end
    end

    // Entry into either mode is the rising edge of its level
    assign clearAll = selLatchRead || (lowPowerEntry && !prevLowPower)
                      || (serialModeEntry && !prevSerial);

    pvs_event_latch uLatch (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .liveStatus (liveStatus),
        .eventMask  (eventMask),
        .clearAll   (clearAll),
        .latchValue (latchValue)
    );

    // Source enable reads the FSM control while hardware owns detection
    assign srcEnEff = softwareChargerControl ? chgReg[`PVS_CHG_SRC_EN]
                                             : fsmSourceControl;
    assign chgView  = {1'b0, srcEnEff, chgReg[5:0]};
    assign accView  = {1'b0, accReg[6:2], dpSingleEndedLevel, dmSingleEndedLevel};

    always_comb begin
        next_chg = chgReg;
        unique case (chgOp)
            2'h1: next_chg = regWdata & `PVS_CHG_WMASK;
            2'h2: next_chg = chgReg | (regWdata & `PVS_CHG_WMASK);
            2'h3: next_chg = chgReg & ~regWdata;
            2'h0: next_chg = chgReg;
        endcase
        if (!softwareChargerControl) begin
            next_chg[`PVS_CHG_SRC_EN] = 1'b0;
        end
        // Only the start of dead-battery detection sets it, so writing 0 still stops it
        if (deadBatteryDetect && !prevDeadBatt) begin
            next_chg[`PVS_CHG_FSM_EN] = 1'b1;
        end
        if (softwareChargerControl || sessionConnectTimeout) begin
            next_chg[`PVS_CHG_FSM_EN] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chgReg <= `PVS_CHG_RESET;
        end else begin
            chgReg <= next_chg;
        end
    end

    always_comb begin
        next_acc = accReg;
        unique case (accOp)
            2'h1: next_acc = regWdata & `PVS_ACC_WMASK;
            2'h2: next_acc = accReg | (regWdata & `PVS_ACC_WMASK);
            2'h3: next_acc = accReg & ~regWdata;
            2'h0: next_acc = accReg;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            accReg <= `PVS_ACC_RESET;
        end else begin
            accReg <= next_acc;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (regRead && addrMapped) begin
            unique case (regAddr)
                `PVS_ADDR_LIVE:  next_rdata = liveStatus;
                `PVS_ADDR_LATCH: next_rdata = latchValue;
                `PVS_ADDR_CHG, `PVS_ADDR_CHG_SET, `PVS_ADDR_CHG_CLR:
                    next_rdata = chgView;
                default: next_rdata = accView;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_rdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chargerFsmRun                 <= 1'b0;
            contactDetectStep             <= 1'b0;
            dataContactSourceOn           <= 1'b0;
            dmPulldownOn                  <= 1'b0;
            idWeakPullupSample            <= 1'b0;
            regulatorVoltageSelect        <= 3'h3;
            accessoryDetectEnable         <= 1'b1;
            aDeviceVbusResistorEnable     <= 1'b1;
            externalSeriesResistorPresent <= 1'b1;
            powerSwitchMode               <= PVS_PSW_OPEN_SOURCE;
        end else begin
            chargerFsmRun <= chgReg[`PVS_CHG_FSM_EN] && !softwareChargerControl;
            contactDetectStep <= chgReg[`PVS_CHG_FSM_EN] && !softwareChargerControl
                                 && chgReg[`PVS_CHG_DCD_EN];
            dataContactSourceOn <= srcEnEff && !dpVoltageSourceEnable;
            dmPulldownOn <= srcEnEff && !dpVoltageSourceEnable;
            idWeakPullupSample <= chgReg[`PVS_CHG_WKPU] && !idMainPullup;
            regulatorVoltageSelect <= chgReg[2:0];
            accessoryDetectEnable <= accReg[`PVS_ACC_ACA_EN];
            aDeviceVbusResistorEnable <= accReg[`PVS_ACC_RABUS];
            externalSeriesResistorPresent <= accReg[`PVS_ACC_R1K];
            if (accReg[`PVS_ACC_CMOS]) begin
                powerSwitchMode <= PVS_PSW_PUSH_PULL;
            end else if (accReg[`PVS_ACC_OSOD]) begin
                powerSwitchMode <= PVS_PSW_OPEN_DRAIN;
            end else begin
                powerSwitchMode <= PVS_PSW_OPEN_SOURCE;
            end
        end
    end

    AST_LIVE_READ: assert property (@(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == `PVS_ADDR_LIVE) |=> regRdata == $past(liveStatus))
        else $error("live status read mismatch");
    AST_FSM_RUN: assert property (@(posedge core_clk) disable iff (!nrst)
        chargerFsmRun |-> $past(chgReg[`PVS_CHG_FSM_EN] && !softwareChargerControl))
        else $error("fsm runs without enable");
    AST_SW_CLEARS_EN: assert property (@(posedge core_clk) disable iff (!nrst)
        softwareChargerControl |=> !chgReg[`PVS_CHG_FSM_EN])
        else $error("fsm enable kept under software control");
    AST_TIMEOUT_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst)
        sessionConnectTimeout |=> !chgReg[`PVS_CHG_FSM_EN])
        else $error("fsm enable kept after timeout");
    AST_DEAD_BATT_SETS: assert property (@(posedge core_clk) disable iff (!nrst)
        (deadBatteryDetect && !prevDeadBatt && !softwareChargerControl
         && !sessionConnectTimeout)
        |=> chgReg[`PVS_CHG_FSM_EN])
        else $error("dead battery did not set enable");
    AST_CONFLICT: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(dpVoltageSourceEnable) |-> !dataContactSourceOn && !dmPulldownOn)
        else $error("current source on with voltage source");
    AST_WKPU_IGNORED: assert property (@(posedge core_clk) disable iff (!nrst)
        idMainPullup |=> !idWeakPullupSample)
        else $error("weak pullup sample with main pullup");
    AST_SET_ALIAS: assert property (@(posedge core_clk) disable iff (!nrst)
        (chgOp == 2'h2 && !softwareChargerControl && !deadBatteryDetect
         && !sessionConnectTimeout) |=> chgReg[5:0] == $past(chgReg[5:0] | regWdata[5:0]))
        else $error("set alias wrong");
    AST_CLR_ALIAS: assert property (@(posedge core_clk) disable iff (!nrst)
        (accOp == 2'h3) |=> accReg == $past(accReg & ~regWdata))
        else $error("clear alias wrong");
    AST_POWER_SWITCH_PUSH_PULL: assert property (@(posedge core_clk) disable iff (!nrst)
        accReg[`PVS_ACC_CMOS] |=> powerSwitchMode == PVS_PSW_PUSH_PULL)
        else $error("push-pull not forced");
    AST_PSW_DRAIN: assert property (@(posedge core_clk) disable iff (!nrst)
        (accReg[`PVS_ACC_OSOD] && !accReg[`PVS_ACC_CMOS])
        |=> powerSwitchMode == PVS_PSW_OPEN_DRAIN)
        else $error("open drain not selected");
    AST_SRC_MIRROR: assert property (@(posedge core_clk) disable iff (!nrst)
        (regRead && regAddr == `PVS_ADDR_CHG && !softwareChargerControl)
        |=> regRdata[`PVS_CHG_SRC_EN] == $past(fsmSourceControl))
        else $error("source enable does not mirror fsm");
    AST_REG_SELECT: assert property (@(posedge core_clk) disable iff (!nrst)
        regulatorVoltageSelect == $past(chgReg[2:0]))
        else $error("regulator select not driven from register");
    AST_DCD_STEP: assert property (@(posedge core_clk) disable iff (!nrst)
        contactDetectStep |-> $past(chgReg[`PVS_CHG_DCD_EN] && chgReg[`PVS_CHG_FSM_EN]))
        else $error("contact detect step without enables");
    AST_RABUS: assert property (@(posedge core_clk) disable iff (!nrst)
        aDeviceVbusResistorEnable == $past(accReg[`PVS_ACC_RABUS]))
        else $error("vbus resistor enable wrong");
    AST_ACA_ENABLE: assert property (@(posedge core_clk) disable iff (!nrst)
        accessoryDetectEnable == $past(accReg[`PVS_ACC_ACA_EN]))
        else $error("accessory detect enable wrong");
endmodule : pvs_vendor_regs

// File: pvs_vendor_regs_tb.sv
// Self-checking testbench of the vendor register bank
`include "pvs_map.svh"
module pvs_vendor_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pvs_pkg::*;

    logic           core_clk, nrst;
    logic           regWrite, regRead;
    pvs_byte_t      regAddr, regWdata, regRdata, eventMask;
    logic           vbus, batt, wdog, idf, bval, lowPower, serialMode;
    logic [1:0]     accCode;
    logic           swCtl, dpVsrc, dpWkpu, idMain, fsmSrc, deadBatt, cntTo, dpLvl, dmLvl;
    logic           fsmRun, dcdStep, srcOn, dmPdOn, wkSample, accDet, aDevRes, extRes;
    logic [2:0]     regSel;
    pvs_psw_mode_t  pswMode;
    int             numErrors = 0;
    int             nTests = 0;

    pvs_vendor_regs pvs_vendor_regs_inst (
        .core_clk(core_clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .vbusMonitorLive(vbus), .batteryLevelMonitorLive(batt),
        .connectWatchdogExpired(wdog), .idLineFloatLive(idf),
        .accessoryResistorCode(accCode), .bSessionValidLive(bval),
        .eventMask(eventMask), .lowPowerEntry(lowPower), .serialModeEntry(serialMode),
        .softwareChargerControl(swCtl), .dpVoltageSourceEnable(dpVsrc),
        .dpWeakPullupEnable(dpWkpu), .idMainPullup(idMain), .fsmSourceControl(fsmSrc),
        .deadBatteryDetect(deadBatt), .sessionConnectTimeout(cntTo),
        .dpSingleEndedLevel(dpLvl), .dmSingleEndedLevel(dmLvl),
        .chargerFsmRun(fsmRun), .contactDetectStep(dcdStep), .dataContactSourceOn(srcOn),
        .dmPulldownOn(dmPdOn), .idWeakPullupSample(wkSample),
        .regulatorVoltageSelect(regSel), .accessoryDetectEnable(accDet),
        .aDeviceVbusResistorEnable(aDevRes), .externalSeriesResistorPresent(extRes),
        .powerSwitchMode(pswMode));

    pvs_link_model pvs_link_model_inst (
        .core_clk(core_clk), .regRdata(regRdata), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input pvs_byte_t a, input pvs_byte_t d);
        pvs_link_model_inst.wr(a, d);
        cyc(2);
    endtask

    task automatic rdc(input pvs_byte_t a, input pvs_byte_t e);
        pvs_byte_t d;
        pvs_link_model_inst.rd(a, d);
        chk(d, e);
    endtask

    task automatic endOfTest;
        $display("comparisons %0d mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic tReset;
        rdc(`PVS_ADDR_CHG, 8'h03);
        rdc(`PVS_ADDR_ACC, 8'h70);
        rdc(`PVS_ADDR_LATCH, 8'h00);
        rdc(8'h40, 8'h00);
        chk(8'(regSel), 8'h03);
        chk(8'(accDet), 8'h01);
        chk(8'(pswMode), 8'h00);
        chk({fsmRun, dcdStep, srcOn, dmPdOn, wkSample, aDevRes, extRes}, 8'h03);
    endtask

    task automatic tLive;
        eventMask = 8'h00;
        for (int k = 0; k < 4; k++) begin
            {batt, vbus} = 2'(k);
            {idf, wdog, bval} = {batt, ~vbus, ~batt};
            accCode = 2'(k);
            cyc(2);
            rdc(`PVS_ADDR_LIVE, {vbus, batt, wdog, idf, accCode, 1'b0, bval});
        end
        rdc(`PVS_ADDR_LATCH, 8'h00);
    endtask

    task automatic tLatch;
        int bits[5] = '{7, 6, 5, 4, 0};
        eventMask = 8'hff;
        cyc(2);
        foreach (bits[i]) begin
            case (bits[i])
                7: vbus = ~vbus;
                6: batt = ~batt;
                5: wdog = ~wdog;
                4: idf = ~idf;
                default: bval = ~bval;
            endcase
            cyc(3);
            rdc(`PVS_ADDR_LATCH, 8'h01 << bits[i]);
            rdc(`PVS_ADDR_LATCH, 8'h00);
        end
        accCode = 2'b01;
        cyc(3);
        rdc(`PVS_ADDR_LATCH, 8'h04);
        accCode = 2'b00;
        cyc(3);
        rdc(`PVS_ADDR_LATCH, 8'h00);
        for (int j = 0; j < 2; j++) begin
            bval = ~bval;
            cyc(3);
            if (j == 0) serialMode = 1'b1;
            else lowPower = 1'b1;
            cyc(3);
            {serialMode, lowPower} = 2'b00;
            rdc(`PVS_ADDR_LATCH, 8'h00);
        end
        fork
            pvs_link_model_inst.wr(8'h40, 8'h00);
            begin
                @(negedge core_clk);
                bval = ~bval;
            end
        join
        cyc(3);
        fork
            begin
                bit [7:0] d;
                pvs_link_model_inst.rd(`PVS_ADDR_LATCH, d);
            end
            begin
                @(negedge core_clk);
                bval = ~bval;
            end
        join
        cyc(3);
        rdc(`PVS_ADDR_LATCH, 8'h01);
    endtask

    task automatic tChg;
        fsmSrc = 1'b1;
        wr(`PVS_ADDR_CHG_SET, 8'h3f);
        rdc(`PVS_ADDR_CHG, 8'h7f);
        rdc(`PVS_ADDR_CHG_SET, 8'h7f);
        chk({fsmRun, dcdStep, wkSample, regSel}, 8'h3f);
        idMain = 1'b1;
        cyc(2);
        chk(8'(wkSample), 8'h00);
        fsmSrc = 1'b0;
        wr(`PVS_ADDR_CHG_CLR, 8'h1a);
        rdc(`PVS_ADDR_CHG, 8'h25);
        chk({fsmRun, regSel}, 8'h05);
        deadBatt = 1'b1;
        cyc(2);
        rdc(`PVS_ADDR_CHG, 8'h35);
        wr(`PVS_ADDR_CHG_CLR, 8'h10);
        rdc(`PVS_ADDR_CHG, 8'h25);
        deadBatt = 1'b0;
        wr(`PVS_ADDR_CHG_SET, 8'h10);
        cntTo = 1'b1;
        cyc(2);
        cntTo = 1'b0;
        rdc(`PVS_ADDR_CHG, 8'h25);
        wr(`PVS_ADDR_CHG_SET, 8'h10);
        swCtl = 1'b1;
        cyc(3);
        rdc(`PVS_ADDR_CHG, 8'h25);
        chk(8'(fsmRun), 8'h00);
        wr(`PVS_ADDR_CHG_SET, 8'h40);
        rdc(`PVS_ADDR_CHG, 8'h65);
        chk({srcOn, dmPdOn}, 8'h03);
        dpVsrc = 1'b1;
        cyc(2);
        chk({srcOn, dmPdOn}, 8'h00);
    endtask

    task automatic tAcc;
        logic [7:0] w[4] = '{8'h70, 8'h78, 8'h74, 8'h0c};
        logic [7:0] m[4] = '{8'h00, 8'h01, 8'h02, 8'h02};
        foreach (w[i]) begin
            wr(`PVS_ADDR_ACC, w[i]);
            chk(8'(pswMode), m[i]);
            chk({accDet, aDevRes, extRes}, 8'(w[i][6:4]));
        end
        wr(`PVS_ADDR_ACC_CLR, 8'h0c);
        {dpLvl, dmLvl} = 2'b10;
        cyc(2);
        rdc(`PVS_ADDR_ACC, 8'h02);
        {dpLvl, dmLvl} = 2'b01;
        cyc(2);
        rdc(`PVS_ADDR_ACC, 8'h01);
    endtask

    initial begin
        nrst = 1'b0;
        {vbus, batt, wdog, idf, bval, lowPower, serialMode} = 7'h00;
        {swCtl, dpVsrc, dpWkpu, idMain, fsmSrc, deadBatt, cntTo, dpLvl, dmLvl} = 9'h000;
        accCode   = 2'b00;
        eventMask = 8'h00;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        tReset;
        tLive;
        tLatch;
        tChg;
        tAcc;
        endOfTest;
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        numErrors++;
        endOfTest;
    end
endmodule // pvs_vendor_regs_tb
